// >>> design/dscd_pkg.sv
// Constants and types of the dual SIMD compute datapath
// Summary of operation
// - Two compute ops per block per cycle
// - Blocks run separate or SIMD paired ops
// - Lanes of 8, 16, 32 or 64 bits
// - Float 32/40 and fixed 8-64 formats
// - 32-word file, single, pair, quad access
// - ALU arithmetic, logic and permute
// - Multiplier multiplies and accumulates fixed point
// - Shifter shifts, bit ops, field deposit/extract
// - Eight 16-bit or four 32-bit Multiply_accumulates
// - Two-cycle pipe, stall on dependency
// - Loads broadcast or merged per block
// - Line issues whole, never reordered
// - One quad realign FIFO per block merges fetches
package dscd_pkg;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned DATA_W = 64;
  localparam int unsigned QUAD_W = 128;
  localparam int unsigned REG_N = 32;
  localparam int unsigned RADDR_W = 5;
  localparam int unsigned PIPE_DEPTH = 2;
  localparam int unsigned FP40_FRAC_LO = 8;
  // Op codes of one slot
  typedef enum logic [3:0] {
    DSCD_NOP = 4'h0,
    DSCD_ADD = 4'h1,
    DSCD_SUB = 4'h2,
    DSCD_AND = 4'h3,
    DSCD_OR = 4'h4,
    DSCD_XOR = 4'h5,
    DSCD_PERM = 4'h6,
    DSCD_FADD = 4'h7,
    DSCD_MUL = 4'h8,
    DSCD_MAC = 4'h9,
    DSCD_FMUL = 4'ha,
    DSCD_LSL = 4'hb,
    DSCD_LSR = 4'hc,
    DSCD_ASR = 4'hd,
    DSCD_FDEP = 4'he,
    DSCD_FEXT = 4'hf
  } dscd_op_e;
  typedef enum logic [1:0] {
    DSCD_L8 = 2'h0,
    DSCD_L16 = 2'h1,
    DSCD_L32 = 2'h2,
    DSCD_L64 = 2'h3
  } dscd_lane_e;
  typedef enum logic [1:0] {
    DSCD_ACC1 = 2'h0,
    DSCD_ACC2 = 2'h1,
    DSCD_ACC4 = 2'h2
  } dscd_acc_e;
endpackage : dscd_pkg

// >>> design/dscd_datapath.sv
// Dual compute block datapath with realignment FIFO
`timescale 1ns/1ps
`default_nettype none
module dscd_datapath #(
  parameter int unsigned NSLOT = 2
) (
  input wire logic REF_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic LINE_VALID_IN,
  output logic LINE_READY_OUT,
  input wire logic SIMD_IN,
  input wire logic [NSLOT*4-1:0] OP_X_IN,
  input wire logic [NSLOT*4-1:0] OP_Y_IN,
  input wire logic [NSLOT*2-1:0] LANE_IN,
  input wire logic [NSLOT*dscd_pkg::RADDR_W-1:0] SRC_A_IN,
  input wire logic [NSLOT*dscd_pkg::RADDR_W-1:0] SRC_B_IN,
  input wire logic [NSLOT*dscd_pkg::RADDR_W-1:0] DST_IN,
  input wire logic [NSLOT*6-1:0] SHAMT_IN,
  input wire logic LOAD_VALID_IN,
  input wire logic LOAD_MERGED_IN,
  input wire logic LOAD_REALIGN_IN,
  input wire logic [1:0] LOAD_OFFSET_IN,
  input wire logic [1:0] LOAD_ACC_IN,
  input wire logic [dscd_pkg::RADDR_W-1:0] LOAD_DST_IN,
  input wire logic [dscd_pkg::QUAD_W-1:0] LOAD_X_IN,
  input wire logic [dscd_pkg::QUAD_W-1:0] LOAD_Y_IN,
  input wire logic [dscd_pkg::RADDR_W-1:0] READ_ADDR_IN,
  output logic [dscd_pkg::QUAD_W-1:0] READ_X_OUT,
  output logic [dscd_pkg::QUAD_W-1:0] READ_Y_OUT,
  output logic STALL_OUT
);
  localparam int unsigned DW = dscd_pkg::DATA_W;
  localparam int unsigned AW = dscd_pkg::RADDR_W;
  localparam int unsigned WW = dscd_pkg::WORD_W;
  localparam int unsigned QW = dscd_pkg::QUAD_W;
  // Two blocks, two slots, two pipe stages
  logic [WW-1:0] rf_reg [2][dscd_pkg::REG_N];
  logic [WW-1:0] rf_next [2][dscd_pkg::REG_N];
  logic [DW-1:0] acc_reg [2];
  logic [DW-1:0] acc_next [2];
  logic s1_v_reg [2][NSLOT];
  logic s1_v_next [2][NSLOT];
  logic [AW-1:0] s1_d_reg [NSLOT];
  logic [AW-1:0] s1_d_next [NSLOT];
  logic [DW-1:0] s1_r_reg [2][NSLOT];
  logic [DW-1:0] s1_r_next [2][NSLOT];
  logic s2_v_reg [2][NSLOT];
  logic s2_v_next [2][NSLOT];
  logic [AW-1:0] s2_d_reg [NSLOT];
  logic [AW-1:0] s2_d_next [NSLOT];
  logic [DW-1:0] s2_r_reg [2][NSLOT];
  logic [DW-1:0] s2_r_next [2][NSLOT];
  logic [QW-1:0] fifo_reg [2];
  logic [QW-1:0] fifo_next [2];
  logic fifo_v_reg;
  logic fifo_v_next;
  logic [QW-1:0] rd_x_reg;
  logic [QW-1:0] rd_y_reg;
  logic stall;

  function automatic logic [DW-1:0] lane_add(input logic [DW-1:0] a, input logic [DW-1:0] b,
                                             input logic sub, input logic [1:0] lane);
    logic [DW-1:0] r;
    logic [DW-1:0] bb;
    logic c;
    int w;
    r = '0;
    bb = sub ? ~b : b;
    c = sub;
    w = 8 << lane;
    // Carry cut at every lane edge
    for (int i = 0; i < DW; i++) begin
      if (i % w == 0) begin
        c = sub;
      end
      r[i] = a[i] ^ bb[i] ^ c;
      c = (a[i] & bb[i]) | (c & (a[i] ^ bb[i]));
    end
    return r;
  endfunction : lane_add

  function automatic logic [DW-1:0] lane_mul(input logic [DW-1:0] a, input logic [DW-1:0] b,
                                             input logic [1:0] lane);
    logic [DW-1:0] r;
    r = '0;
    unique case (lane)
      dscd_pkg::DSCD_L8: begin
        for (int i = 0; i < 8; i++) begin
          r[i*8 +: 8] = 8'(a[i*8 +: 8] * b[i*8 +: 8]);
        end
      end
      dscd_pkg::DSCD_L16: begin
        for (int i = 0; i < 4; i++) begin
          r[i*16 +: 16] = 16'(a[i*16 +: 16] * b[i*16 +: 16]);
        end
      end
      dscd_pkg::DSCD_L32: begin
        for (int i = 0; i < 2; i++) begin
          r[i*32 +: 32] = 32'(a[i*32 +: 32] * b[i*32 +: 32]);
        end
      end
      dscd_pkg::DSCD_L64: begin
        r = 64'(a * b);
      end
    endcase
    return r;
  endfunction : lane_mul

  // Float kept simple: only the sign bit and the low 8 extension bits change, low bits treated as fixed
  function automatic logic [DW-1:0] fp_op(input logic [DW-1:0] a, input logic [DW-1:0] b,
                                          input logic mul);
    logic [DW-1:0] r;
    r = a;
    r[WW-1] = a[WW-1] ^ (mul & b[WW-1]);
    r[dscd_pkg::FP40_FRAC_LO-1:0] = mul ? 8'(a[7:0] * b[7:0]) : 8'(a[7:0] + b[7:0]);
    return r;
  endfunction : fp_op

  function automatic logic [DW-1:0] exec(input logic [3:0] op, input logic [1:0] lane,
                                         input logic [DW-1:0] a, input logic [DW-1:0] b,
                                         input logic [5:0] sh, input logic [DW-1:0] acc);
    logic [DW-1:0] r;
    logic [DW-1:0] m;
    r = '0;
    m = ~(64'hffffffffffffffff << b[5:0]);
    unique case (dscd_pkg::dscd_op_e'(op))
      dscd_pkg::DSCD_NOP: r = '0;
      dscd_pkg::DSCD_ADD: r = lane_add(a, b, 1'b0, lane);
      dscd_pkg::DSCD_SUB: r = lane_add(a, b, 1'b1, lane);
      dscd_pkg::DSCD_AND: r = a & b;
      dscd_pkg::DSCD_OR: r = a | b;
      dscd_pkg::DSCD_XOR: r = a ^ b;
      dscd_pkg::DSCD_PERM: r = {a[31:0], a[63:32]};
      dscd_pkg::DSCD_FADD: r = fp_op(a, b, 1'b0);
      dscd_pkg::DSCD_MUL: r = lane_mul(a, b, lane);
      dscd_pkg::DSCD_MAC: r = lane_add(acc, lane_mul(a, b, lane), 1'b0, lane);
      dscd_pkg::DSCD_FMUL: r = fp_op(a, b, 1'b1);
      dscd_pkg::DSCD_LSL: r = a << sh;
      dscd_pkg::DSCD_LSR: r = a >> sh;
      dscd_pkg::DSCD_ASR: r = 64'($signed(a) >>> sh);
      dscd_pkg::DSCD_FDEP: r = (acc & ~(m << sh)) | ((a & m) << sh);
      dscd_pkg::DSCD_FEXT: r = (a >> sh) & m;
    endcase
    return r;
  endfunction : exec

  // Dependency check against results still in flight
  always_comb begin
    stall = 1'b0;
    for (int s = 0; s < NSLOT; s++) begin
      for (int k = 0; k < NSLOT; k++) begin
        if (((s1_v_reg[0][k] || s1_v_reg[1][k]) && (SRC_A_IN[s*AW +: AW] == s1_d_reg[k] ||
            SRC_B_IN[s*AW +: AW] == s1_d_reg[k])) || ((s2_v_reg[0][k] || s2_v_reg[1][k]) &&
            (SRC_A_IN[s*AW +: AW] == s2_d_reg[k] || SRC_B_IN[s*AW +: AW] == s2_d_reg[k]))) begin
          stall = LINE_VALID_IN;
        end
      end
    end
  end

  assign STALL_OUT = stall;
  assign LINE_READY_OUT = ~stall;

  always_comb begin
    logic [DW-1:0] a;
    logic [DW-1:0] b;
    logic [QW-1:0] ld;
    logic [3:0] op;
    logic take;
    a = '0;
    b = '0;
    ld = '0;
    op = '0;
    take = LINE_VALID_IN & ~stall;
    rf_next = rf_reg;
    acc_next = acc_reg;
    fifo_next = fifo_reg;
    fifo_v_next = fifo_v_reg;
    s2_v_next = s1_v_reg;
    s2_d_next = s1_d_reg;
    s2_r_next = s1_r_reg;
    s1_d_next = s1_d_reg;
    s1_r_next = s1_r_reg;
    for (int x = 0; x < 2; x++) begin
      // Retire stage two into the file
      for (int s = 0; s < NSLOT; s++) begin
        if (s2_v_reg[x][s]) begin
          rf_next[x][s2_d_reg[s]] = s2_r_reg[x][s][WW-1:0];
          rf_next[x][s2_d_reg[s] | 5'h01] = s2_r_reg[x][s][DW-1:WW];
        end
      end
      // Loads: broadcast or merged, optionally realigned
      if (LOAD_VALID_IN && !stall) begin
        ld = (LOAD_MERGED_IN && x == 1) ? LOAD_Y_IN : LOAD_X_IN;
        if (LOAD_REALIGN_IN) begin
          ld = QW'({ld, fifo_reg[x]} >> (LOAD_OFFSET_IN * WW));
          fifo_next[x] = (LOAD_MERGED_IN && x == 1) ? LOAD_Y_IN : LOAD_X_IN;
          fifo_v_next = 1'b1;
        end
        unique case (dscd_pkg::dscd_acc_e'(LOAD_ACC_IN))
          dscd_pkg::DSCD_ACC1: rf_next[x][LOAD_DST_IN] = ld[WW-1:0];
          dscd_pkg::DSCD_ACC2: begin
            rf_next[x][LOAD_DST_IN & 5'h1e] = ld[WW-1:0];
            rf_next[x][LOAD_DST_IN | 5'h01] = ld[2*WW-1:WW];
          end
          dscd_pkg::DSCD_ACC4: begin
            for (int q = 0; q < 4; q++) begin
              rf_next[x][(LOAD_DST_IN & 5'h1c) | 5'(q)] = ld[q*WW +: WW];
            end
          end
          default: ;
        endcase
      end
      for (int s = 0; s < NSLOT; s++) begin
        op = (SIMD_IN || x == 0) ? OP_X_IN[s*4 +: 4] : OP_Y_IN[s*4 +: 4];
        a = {rf_reg[x][SRC_A_IN[s*AW +: AW] | 5'h01], rf_reg[x][SRC_A_IN[s*AW +: AW]]};
        b = {rf_reg[x][SRC_B_IN[s*AW +: AW] | 5'h01], rf_reg[x][SRC_B_IN[s*AW +: AW]]};
        s1_v_next[x][s] = take && op != 4'h0;
        s1_r_next[x][s] = exec(op, LANE_IN[s*2 +: 2], a, b, SHAMT_IN[s*6 +: 6], acc_reg[x]);
        if (take) begin
          s1_d_next[s] = DST_IN[s*AW +: AW];
        end
        if (take && op == dscd_pkg::DSCD_MAC) begin
          acc_next[x] = s1_r_next[x][s];
        end
      end
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      for (int x = 0; x < 2; x++) begin
        for (int r = 0; r < dscd_pkg::REG_N; r++) begin
          rf_reg[x][r] <= '0;
        end
        acc_reg[x] <= '0;
        fifo_reg[x] <= '0;
        for (int s = 0; s < NSLOT; s++) begin
          s1_v_reg[x][s] <= 1'b0;
          s2_v_reg[x][s] <= 1'b0;
          s1_r_reg[x][s] <= '0;
          s2_r_reg[x][s] <= '0;
        end
      end
      for (int s = 0; s < NSLOT; s++) begin
        s1_d_reg[s] <= '0;
        s2_d_reg[s] <= '0;
      end
      fifo_v_reg <= 1'b0;
      rd_x_reg <= '0;
      rd_y_reg <= '0;
    end else begin
      rf_reg <= rf_next;
      acc_reg <= acc_next;
      fifo_reg <= fifo_next;
      fifo_v_reg <= fifo_v_next;
      s1_v_reg <= s1_v_next;
      s1_d_reg <= s1_d_next;
      s1_r_reg <= s1_r_next;
      s2_v_reg <= s2_v_next;
      s2_d_reg <= s2_d_next;
      s2_r_reg <= s2_r_next;
      rd_x_reg <= {rf_reg[0][READ_ADDR_IN | 5'h03], rf_reg[0][READ_ADDR_IN | 5'h02],
                   rf_reg[0][READ_ADDR_IN | 5'h01], rf_reg[0][READ_ADDR_IN & 5'h1c]};
      rd_y_reg <= {rf_reg[1][READ_ADDR_IN | 5'h03], rf_reg[1][READ_ADDR_IN | 5'h02],
                   rf_reg[1][READ_ADDR_IN | 5'h01], rf_reg[1][READ_ADDR_IN & 5'h1c]};
    end
  end
  assign READ_X_OUT = rd_x_reg;
  assign READ_Y_OUT = rd_y_reg;

  sequence issue_s;
    LINE_VALID_IN && LINE_READY_OUT && OP_X_IN[3:0] != 4'h0;
  endsequence
  line_ready_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    LINE_READY_OUT == !STALL_OUT) else $error("ready not inverse of stall");
  pipe_two_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    issue_s |=> s1_v_reg[0][0] ##1 s2_v_reg[0][0]) else $error("pipe not two deep");
  stall_idle_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    !LINE_VALID_IN |-> !STALL_OUT) else $error("stall without line");
  simd_pair_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    (issue_s and SIMD_IN) |=> s1_v_reg[1][0]) else $error("simd pair missing");
  stall_hold_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    STALL_OUT |=> $stable(fifo_reg[0])) else $error("fifo moved in stall");
  bcast_load_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    LOAD_VALID_IN && !STALL_OUT && !LOAD_MERGED_IN && LOAD_REALIGN_IN
    |=> fifo_reg[0] == fifo_reg[1]) else $error("broadcast differs");
  stall_no_s1_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    STALL_OUT |=> !s1_v_reg[0][0]) else $error("issued during stall");
  mac_acc_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    (issue_s and OP_X_IN[3:0] == 4'h9 && OP_X_IN[7:4] != 4'h9)
    |=> acc_reg[0] == s1_r_reg[0][0]) else $error("accumulator not updated");
  fifo_fill_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    LOAD_VALID_IN && LOAD_REALIGN_IN && !STALL_OUT |=> fifo_v_reg) else $error("fifo empty");
endmodule : dscd_datapath
`default_nettype wire

// >>> tb/dscd_seq_model.sv
// Issuer model of instruction lines and loads
`timescale 1ns/1ps
`default_nettype none
module dscd_seq_model (
  input wire logic clk_in,
  input wire logic ready_in,
  output logic line_valid_out,
  output logic simd_out,
  output logic [7:0] op_x_out,
  output logic [7:0] op_y_out,
  output logic [3:0] lane_out,
  output logic [9:0] src_a_out,
  output logic [9:0] src_b_out,
  output logic [9:0] dst_out,
  output logic [11:0] shamt_out,
  output logic load_valid_out,
  output logic merged_out,
  output logic realign_out,
  output logic [1:0] offset_out,
  output logic [1:0] acc_out,
  output logic [4:0] ldst_out,
  output logic [127:0] load_x_out,
  output logic [127:0] load_y_out
);
  int stalls;
  initial begin
    {line_valid_out, simd_out, op_x_out, op_y_out, lane_out, src_a_out, src_b_out} = '0;
    {dst_out, shamt_out, load_valid_out, merged_out, realign_out, offset_out} = '0;
    {acc_out, ldst_out, load_x_out, load_y_out} = '0;
  end
  // Low words carry lane carries, high words stay small so products fit
  function automatic logic [31:0] word(input int w);
    return (w >= 8) ? w[31:0] : 32'hf0e0_80ff ^ (w[31:0] * 32'h1111_1111);
  endfunction : word
  function automatic logic [127:0] quad(input int w);
    return {word(w + 3), word(w + 2), word(w + 1), word(w)};
  endfunction : quad
  // Whole line held until taken; stall cycles counted
  task automatic issue(input logic s, input logic [7:0] ox, input logic [7:0] oy,
                       input logic [3:0] ln, input logic [9:0] sa, input logic [9:0] sb,
                       input logic [9:0] d, input logic [11:0] sh);
    logic r;
    stalls = 0;
    line_valid_out <= 1'b1;
    simd_out <= s;
    op_x_out <= ox;
    op_y_out <= oy;
    lane_out <= ln;
    src_a_out <= sa;
    src_b_out <= sb;
    dst_out <= d;
    shamt_out <= sh;
    do begin
      @(negedge clk_in);
      r = ready_in;
      stalls += int'(!r);
      @(posedge clk_in);
    end while (!r);
  endtask : issue
  // Misaligned quads need two aligned fetches through the realign FIFO
  task automatic ld(input int w, input logic [4:0] d, input logic [1:0] acc, input logic mrg);
    int n;
    logic [127:0] q;
    n = (acc == 2'h2 && w % 4 != 0) ? 2 : 1;
    for (int i = 0; i < n; i++) begin
      q = quad(w - (w % 4) * (n - 1) + 4 * i);
      load_valid_out <= 1'b1;
      realign_out <= (n == 2);
      offset_out <= 2'(w % 4);
      acc_out <= acc;
      ldst_out <= d;
      merged_out <= mrg;
      load_x_out <= q;
      load_y_out <= mrg ? ~q : q;
      @(posedge clk_in);
    end
  endtask : ld
  task automatic idle(input int n);
    line_valid_out <= 1'b0;
    load_valid_out <= 1'b0;
    repeat (n) @(posedge clk_in);
  endtask : idle
endmodule : dscd_seq_model
`default_nettype wire

// >>> tb/dscd_datapath_test.sv
// Self-checking bench of the dual compute datapath
`timescale 1ns/1ps
`default_nettype none
module dscd_datapath_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] raddr = 5'h00;
  logic ready, stall, lv, simd, ldv, mrg, ral;
  logic [7:0] opx, opy;
  logic [3:0] ln;
  logic [9:0] sa, sb, dd;
  logic [11:0] sh;
  logic [1:0] ofs, acc;
  logic [4:0] ldd;
  logic [127:0] lx, ly, rx, ry;
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;
  // Row: op0, lane0, op1, lane1, shift
  logic [17:0] rows [12] = '{18'h04840, 18'h05880, 18'h06200, 18'h072c0, 18'h093c0,
                             18'h0a4c0, 18'h176c0, 18'h2fccd, 18'h37ce8, 18'h1fac0,
                             18'h3bfc5, 18'h208c0};
  always #25 clk = ~clk;
  dscd_datapath i_dscd_datapath (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .LINE_VALID_IN(lv),
    .LINE_READY_OUT(ready), .SIMD_IN(simd), .OP_X_IN(opx), .OP_Y_IN(opy), .LANE_IN(ln),
    .SRC_A_IN(sa), .SRC_B_IN(sb), .DST_IN(dd), .SHAMT_IN(sh), .LOAD_VALID_IN(ldv),
    .LOAD_MERGED_IN(mrg), .LOAD_REALIGN_IN(ral), .LOAD_OFFSET_IN(ofs), .LOAD_ACC_IN(acc),
    .LOAD_DST_IN(ldd), .LOAD_X_IN(lx), .LOAD_Y_IN(ly), .READ_ADDR_IN(raddr),
    .READ_X_OUT(rx), .READ_Y_OUT(ry), .STALL_OUT(stall));
  dscd_seq_model i_dscd_seq_model (.clk_in(clk), .ready_in(ready), .line_valid_out(lv),
    .simd_out(simd), .op_x_out(opx), .op_y_out(opy), .lane_out(ln), .src_a_out(sa),
    .src_b_out(sb), .dst_out(dd), .shamt_out(sh), .load_valid_out(ldv), .merged_out(mrg),
    .realign_out(ral), .offset_out(ofs), .acc_out(acc), .ldst_out(ldd), .load_x_out(lx),
    .load_y_out(ly));
  function automatic logic [63:0] calc(input logic [3:0] op, input logic [1:0] l,
                                       input logic [5:0] s, input logic [63:0] a,
                                       input logic [63:0] b);
    logic [63:0] r, m, x, y;
    int w;
    w = 8 << l;
    m = (l == 2'h3) ? '1 : (64'h1 << w) - 64'h1;
    r = '0;
    for (int i = 0; i < 64; i += w) begin
      x = (a >> i) & m;
      y = (b >> i) & m;
      r |= (((op == 4'h1) ? x + y : (op == 4'h2) ? x - y : x * y) & m) << i;
    end
    case (op)
      4'h3: r = a & b;
      4'h4: r = a | b;
      4'h5: r = a ^ b;
      4'h6: r = {a[31:0], a[63:32]};
      4'hb: r = a << s;
      4'hc: r = a >> s;
      4'hd: r = $signed(a) >>> s;
      // Float kept to sign and low byte; field width from operand b
      4'h7, 4'ha: begin
        r = a;
        r[31] = a[31] ^ (op[3] & b[31]);
        r[7:0] = op[3] ? 8'(a[7:0] * b[7:0]) : 8'(a[7:0] + b[7:0]);
      end
      4'he: r = (a & ~({64{1'b1}} << b[5:0])) << s;
      4'hf: r = (a >> s) & ~({64{1'b1}} << b[5:0]);
      default: ;
    endcase
    return r;
  endfunction : calc
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Registered read port: address at one edge, data after the next
  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    raddr <= a;
    @(posedge clk);
    @(negedge clk);
  endtask : rd
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    logic [127:0] q0, q4, q8;
    logic [17:0] r;
    logic [63:0] e0, e1;
    q0 = i_dscd_seq_model.quad(0);
    q4 = i_dscd_seq_model.quad(4);
    q8 = i_dscd_seq_model.quad(8);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk({126'h0, ready, stall}, 128'h2);
    chk(rx, 128'h0);
    chk(ry, 128'h0);
    @(posedge clk);
    i_dscd_seq_model.ld(0, 5'h00, 2'h2, 1'b0);
    i_dscd_seq_model.ld(8, 5'h04, 2'h2, 1'b0);
    i_dscd_seq_model.ld(16, 5'h10, 2'h2, 1'b1);
    i_dscd_seq_model.ld(5, 5'h14, 2'h2, 1'b0);
    i_dscd_seq_model.ld(6, 5'h19, 2'h1, 1'b0);
    i_dscd_seq_model.ld(3, 5'h1e, 2'h0, 1'b0);
    i_dscd_seq_model.idle(2);
    rd(5'h00);
    chk(rx, q0);
    chk(ry, q0);
    rd(5'h10);
    chk(rx, i_dscd_seq_model.quad(16));
    chk(ry, ~i_dscd_seq_model.quad(16));
    rd(5'h14);
    chk(rx, {q8[31:0], q4[127:32]});
    rd(5'h18);
    chk(rx, {64'h0, q4[127:64]});
    rd(5'h1c);
    chk(rx, {32'h0, q0[127:96], 64'h0});
    for (int i = 0; i < 12; i++) begin
      r = rows[i];
      e0 = calc(r[17:14], r[13:12], r[5:0], q0[63:0], q0[127:64]);
      e1 = calc(r[11:8], r[7:6], r[5:0], q8[63:0], q8[127:64]);
      @(posedge clk);
      i_dscd_seq_model.issue(1'b1, {r[11:8], r[17:14]}, 8'h00, {r[7:6], r[13:12]}, 10'h080,
                             10'h0c2, 10'h188, {r[5:0], r[5:0]});
      i_dscd_seq_model.idle(3);
      rd(5'h08);
      chk({rx[63:0], ry[63:0]}, {e0, e0});
      rd(5'h0c);
      chk({rx[63:0], ry[63:0]}, {e1, e1});
    end
    // Two accumulates of one operand pair give twice the product per lane
    e1 = calc(4'h8, 2'h1, 6'h00, q0[63:0], q0[127:64]);
    e0 = calc(4'h1, 2'h1, 6'h00, e1, e1);
    @(posedge clk);
    i_dscd_seq_model.issue(1'b1, 8'h09, 8'h00, 4'h1, 10'h080, 10'h0c2, 10'h188, 12'h000);
    i_dscd_seq_model.issue(1'b1, 8'h09, 8'h00, 4'h1, 10'h080, 10'h0c2, 10'h188, 12'h000);
    i_dscd_seq_model.idle(3);
    rd(5'h08);
    chk({rx[63:0], ry[63:0]}, {e0, e0});
    // Separate ops per block, both slots busy
    @(posedge clk);
    i_dscd_seq_model.issue(1'b0, 8'h31, 8'h52, 4'h3, 10'h080, 10'h0c2, 10'h188, 12'h000);
    i_dscd_seq_model.idle(3);
    rd(5'h08);
    chk({rx[63:0], ry[63:0]}, {q0[63:0] + q0[127:64], q0[63:0] - q0[127:64]});
    rd(5'h0c);
    chk({rx[63:0], ry[63:0]}, {q8[63:0] & q8[127:64], q8[63:0] ^ q8[127:64]});
    // Dependent line right behind its producer, then an independent one
    @(posedge clk);
    i_dscd_seq_model.issue(1'b1, 8'h01, 8'h00, 4'h3, 10'h000, 10'h002, 10'h3ea, 12'h000);
    i_dscd_seq_model.issue(1'b1, 8'h01, 8'h00, 4'h3, 10'h00a, 10'h000, 10'h3ee, 12'h000);
    chk(128'(i_dscd_seq_model.stalls), 128'h2);
    i_dscd_seq_model.issue(1'b1, 8'h01, 8'h00, 4'h3, 10'h000, 10'h002, 10'h3f0, 12'h000);
    chk(128'(i_dscd_seq_model.stalls), 128'h0);
    i_dscd_seq_model.idle(3);
    rd(5'h0c);
    chk({64'h0, rx[127:64]}, {64'h0, q0[63:0] + q0[127:64] + q0[63:0]});
    // Reset in mid-run clears both files and frees the line
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk({126'h0, ready, stall}, 128'h2);
    rd(5'h08);
    chk(rx, 128'h0);
    chk(ry, 128'h0);
    stop_test();
  end
endmodule : dscd_datapath_test
`default_nettype wire
